/* bench/aphi_checker.sv */
// concurrent checks on the converter host port
// bound to aphi_parallel_port; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module aphi_checker
   import aphi_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // host pins
   input wire logic conversion_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic read_n_in,
   input wire logic write_n_in,
   input wire logic word_mode_in,
   // core and outputs
   input wire logic [DATA_W-1:0] conv_code_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic [DATA_W-1:0] data_oe_out,
   input wire logic busy_out,
   input wire logic sampler_track_out,
   input wire logic [1:0] power_mode_out,
   input wire logic standby_out,
   input wire logic powered_down_out,
   input wire logic [DATA_W-1:0] control_word_out,
   input wire aphi_result_t stream_data_out,
   input wire logic stream_valid_out,
   input wire logic stream_ready_in
);
   logic [3:0] rd_on_reg, rd_off_reg, wr_off_reg;
   logic rd_act, wr_act;
   assign rd_act = !chip_select_n_in && !read_n_in;
   assign wr_act = !chip_select_n_in && !write_n_in;
   // saturating counts of strobe activity, since pins reach the port late
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rd_on_reg <= 4'h0;
         rd_off_reg <= 4'hf;
         wr_off_reg <= 4'hf;
      end
      else
      begin
         rd_on_reg <= rd_act ? rd_on_reg + {3'h0, rd_on_reg != 4'hf} : 4'h0;
         rd_off_reg <= rd_act ? 4'h0 : rd_off_reg + {3'h0, rd_off_reg != 4'hf};
         wr_off_reg <= wr_act ? 4'h0 : wr_off_reg + {3'h0, wr_off_reg != 4'hf};
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   a_busy_on_start: assert property ($fell(conversion_start_n_in) && !busy_out &&
      power_mode_out != PM_FULL_OFF |-> ##[3:8] busy_out) else $error("busy late");
   a_hold_at_start: assert property ($rose(busy_out) |-> !sampler_track_out)
      else $error("sampler not held");
   a_track_at_end: assert property ($fell(busy_out) && power_mode_out == PM_NORMAL
      |-> ##[0:1] sampler_track_out) else $error("sampler not tracking");
   a_word_leads_busy: assert property ($fell(busy_out) && !conversion_start_n_in &&
      data_oe_out == OE_WORD |-> data_out == conv_code_in && $past(data_out) == conv_code_in)
      else $error("result late on bus");
   a_read_drives: assert property (rd_on_reg >= 4'h8 |->
      data_oe_out == (word_mode_in ? OE_WORD : OE_BYTE)) else $error("bus not driven");
   a_read_release: assert property (rd_off_reg >= 4'h8 |-> data_oe_out == OE_NONE)
      else $error("bus not released");
   a_byte_top_zero: assert property (data_oe_out == OE_BYTE |-> data_out[11:8] == 4'h0)
      else $error("byte read upper lines");
   a_ctrl_on_release: assert property ($changed(control_word_out) |->
      wr_off_reg inside {[4'h1:4'ha]}) else $error("control changed off release");
   a_no_conv_off: assert property ($rose(busy_out) |-> power_mode_out != PM_FULL_OFF)
      else $error("converted while off");
   a_normal_on: assert property ((power_mode_out == PM_NORMAL)[*3] |->
      !standby_out && !powered_down_out) else $error("normal mode powered down");
   a_stream_hold: assert property (stream_valid_out && !stream_ready_in |=>
      stream_valid_out && $stable(stream_data_out)) else $error("stream word dropped");
   c_done: cover property ($fell(busy_out));
   c_byte_read: cover property (rd_on_reg == 4'h8 && !word_mode_in);
   c_stall: cover property (stream_valid_out && !stream_ready_in && busy_out);
endmodule
bind aphi_parallel_port aphi_checker u_aphi_checker (.clk_in(clk_in), .reset_in(reset_in),
   .conversion_start_n_in(conversion_start_n_in), .chip_select_n_in(chip_select_n_in),
   .read_n_in(read_n_in), .write_n_in(write_n_in), .word_mode_in(word_mode_in),
   .conv_code_in(conv_code_in), .data_out(data_out), .data_oe_out(data_oe_out),
   .busy_out(busy_out), .sampler_track_out(sampler_track_out),
   .power_mode_out(power_mode_out), .standby_out(standby_out),
   .powered_down_out(powered_down_out), .control_word_out(control_word_out),
   .stream_data_out(stream_data_out), .stream_valid_out(stream_valid_out),
   .stream_ready_in(stream_ready_in));
`default_nettype wire

/* bench/aphi_host_model.sv */
// host side of the port: strobes, data lines, conversion clock
// assumes the port answers on clk_in; pins move 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module aphi_host_model
   import aphi_pkg::*;
(
   // clock
   input wire logic clk_in,
   // pins toward the port
   output aphi_pins_t pins_out,
   output logic [DATA_W-1:0] bus_out,
   // port answers
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] oe_in,
   input wire logic busy_in
);
   aphi_pins_t p = PINS_IDLE;
   logic [DATA_W-1:0] drv = 12'h000;
   assign pins_out = p;
   // released lines show the host's drv value; write_cycle sets it to the inverse after a write, never a stale copy
   assign bus_out = (oe_in & data_in) | (~oe_in & drv);
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // four samples per level keeps every conversion clock edge visible
   always
   begin
      step(4);
      p.conv_clk = ~p.conv_clk;
   end
   task automatic write_cycle(input logic wm, input logic [DATA_W-1:0] d);
      step(1);
      p.word_mode = wm;
      drv = d;
      step(4);
      p.cs_n = 1'b0;
      p.wr_n = 1'b0;
      step(6);
      p.cs_n = 1'b1;
      p.wr_n = 1'b1;
      step(6);
      drv = ~d;
      step(8);
   endtask
   task automatic read_cycle(input logic wm, input logic hi, output logic [DATA_W-1:0] q,
      output logic [DATA_W-1:0] oe);
      step(1);
      p.word_mode = wm;
      drv = {3'h0, hi, 8'h00};
      step(4);
      p.cs_n = 1'b0;
      p.rd_n = 1'b0;
      step(10);
      q = bus_out;
      oe = oe_in;
      p.cs_n = 1'b1;
      p.rd_n = 1'b1;
      step(10);
   endtask
   // strobes held low rather than pulsed while converting
   task automatic hold_read(input logic on);
      step(1);
      p.cs_n = !on;
      p.rd_n = !on;
      step(6);
   endtask
   task automatic begin_conv(output logic seen);
      int n;
      step(1);
      p.start_n = 1'b0;
      seen = 1'b0;
      for (n = 0; n < 12; n++)
      begin
         step(1);
         seen = seen | busy_in;
      end
   endtask
   task automatic wait_idle(input int limit, output logic done);
      int n;
      for (n = 0; n < limit && busy_in; n++)
         step(1);
      done = !busy_in;
      step(4);
   endtask
   // called only once busy is low, so no conversion is cut short
   task automatic rise_start;
      step(1);
      p.start_n = 1'b1;
      step(40);
   endtask
   task automatic abort_conv;
      step(1);
      p.start_n = 1'b0;
      step(40);
      p.start_n = 1'b1;
      step(40);
   endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the converter host port
// assumes aphi_host_model drives the pins and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   import aphi_pkg::*;
   logic clk_in, reset_in, stream_ready_in, ok;
   logic [DATA_W-1:0] conv_code_in, data_out, data_oe_out, bus, control_word_out, q, oe;
   logic [CHAN_W-1:0] conv_channel_in;
   logic busy_out, sampler_track_out, standby_out, powered_down_out, stream_valid_out;
   logic [1:0] power_mode_out;
   logic [MASK_W-1:0] channel_mask_out;
   aphi_result_t stream_data_out;
   aphi_pins_t pins;
   aphi_result_t got[$];
   int n_fail, n_compared;
   aphi_parallel_port u_aphi_parallel_port (.clk_in(clk_in), .reset_in(reset_in),
      .conversion_start_n_in(pins.start_n), .conversion_clock_in(pins.conv_clk),
      .chip_select_n_in(pins.cs_n), .read_n_in(pins.rd_n), .write_n_in(pins.wr_n),
      .word_mode_in(pins.word_mode), .data_in(bus), .data_out(data_out),
      .data_oe_out(data_oe_out), .conv_code_in(conv_code_in), .conv_channel_in(conv_channel_in),
      .busy_out(busy_out), .sampler_track_out(sampler_track_out),
      .power_mode_out(power_mode_out), .standby_out(standby_out),
      .powered_down_out(powered_down_out), .control_word_out(control_word_out),
      .channel_mask_out(channel_mask_out), .stream_data_out(stream_data_out),
      .stream_valid_out(stream_valid_out), .stream_ready_in(stream_ready_in));
   aphi_host_model u_host (.clk_in(clk_in), .pins_out(pins), .bus_out(bus),
      .data_in(data_out), .oe_in(data_oe_out), .busy_in(busy_out));
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
      if (!reset_in && stream_valid_out && stream_ready_in)
         got.push_back(stream_data_out);
   task automatic end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // tests take about 4000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      $display("BAD t=%0t timeout", $time);
      end_sim();
   end
   initial
   begin
      n_fail = 0;
      n_compared = 0;
      reset_in = 1'b1;
      stream_ready_in = 1'b1;
      conv_code_in = 12'h5a3;
      conv_channel_in = 3'h6;
      repeat (10) @(posedge clk_in);
      #1 reset_in = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      `CHK({busy_out, sampler_track_out, power_mode_out, standby_out, powered_down_out}, 6'h00)
      `CHK({control_word_out, channel_mask_out, data_oe_out, stream_valid_out}, 33'h0)
      $display("test reset done");
      u_host.hold_read(1'b1);
      u_host.begin_conv(ok);
      `CHK({ok, sampler_track_out}, 2'b10)
      u_host.wait_idle(300, ok);
      `CHK(ok, 1'b1)
      `CHK({data_oe_out, data_out}, {OE_WORD, 12'h5a3})
      `CHK(got[0], aphi_result_t'({3'h6, 12'h5a3}))
      u_host.rise_start();
      `CHK({standby_out, powered_down_out, sampler_track_out}, 3'b001)
      u_host.hold_read(1'b0);
      got.delete();
      $display("test conversion done");
      u_host.read_cycle(1'b0, 1'b0, q, oe);
      `CHK({oe, q}, {OE_BYTE, 12'h0a3})
      u_host.read_cycle(1'b0, 1'b1, q, oe);
      `CHK({oe, q}, {OE_BYTE, 12'h165})
      u_host.read_cycle(1'b1, 1'b0, q, oe);
      `CHK({oe, q}, {OE_WORD, 12'h5a3})
      `CHK(data_oe_out, OE_NONE)
      $display("test reads done");
      u_host.abort_conv();
      `CHK({busy_out, sampler_track_out, stream_valid_out}, 3'b010)
      $display("test abort done");
      u_host.write_cycle(1'b1, 12'ha85);
      `CHK(control_word_out, 12'ha85)
      u_host.write_cycle(1'b0, 12'h007);
      `CHK(control_word_out, 12'ha85)
      u_host.write_cycle(1'b0, 12'h101);
      `CHK(control_word_out, 12'h107)
      u_host.write_cycle(1'b1, 12'h008);
      u_host.write_cycle(1'b0, 12'h0c5);
      `CHK(channel_mask_out, 8'hc5)
      u_host.write_cycle(1'b1, 12'h008);
      u_host.write_cycle(1'b1, 12'h0c2);
      `CHK(channel_mask_out, 8'hc2)
      $display("test writes done");
      for (int m = 1; m < 3; m++)
      begin
         u_host.write_cycle(1'b1, {6'h00, m[1:0], 4'h0});
         u_host.begin_conv(ok);
         u_host.wait_idle(300, ok);
         `CHK({standby_out, powered_down_out, sampler_track_out}, {m[1], m[0], 1'b0})
         u_host.rise_start();
         `CHK({standby_out, powered_down_out, sampler_track_out}, 3'b001)
      end
      u_host.write_cycle(1'b1, 12'h030);
      `CHK({powered_down_out, sampler_track_out, power_mode_out}, 4'hb)
      u_host.begin_conv(ok);
      `CHK(ok, 1'b0)
      u_host.rise_start();
      `CHK({powered_down_out, sampler_track_out}, 2'b10)
      u_host.write_cycle(1'b1, 12'h000);
      `CHK({powered_down_out, standby_out, sampler_track_out}, 3'b001)
      got.delete();
      $display("test power done");
      stream_ready_in = 1'b0;
      for (int i = 0; i <= FIFO_DEPTH + 1; i++)
      begin
         conv_code_in = 12'h100 + i[11:0];
         u_host.begin_conv(ok);
         u_host.wait_idle(200, ok);
         `CHK(ok, i <= FIFO_DEPTH)
         if (ok)
            u_host.rise_start();
      end
      stream_ready_in = 1'b1;
      u_host.wait_idle(400, ok);
      `CHK(ok, 1'b1)
      u_host.rise_start();
      `CHK(got.size(), FIFO_DEPTH + 2)
      for (int i = 0; i <= FIFO_DEPTH + 1; i++)
         `CHK(got[i], aphi_result_t'({3'h6, 12'h100 + i[11:0]}))
      $display("test buffer done");
      end_sim();
   end
endmodule
`default_nettype wire

/* rtl/aphi_parallel_port.sv */
// parallel host port of an eight-channel 12-bit sampling converter
// assumes host pins are asynchronous to clk_in and the converter core
// presents code and channel on clk_in when the conversion ends
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - twelve data lines; width select picks word/byte
// - start falling edge begins conversion, raises busy
// - start rising before 14th clock fall aborts
// - busy falls when conversion completes; the code holds it high while the result FIFO is full
// - after reset hold; first start rise tracks
// - hold on start fall, track on 13th rise
// - auto power-down modes wake on start rise
// - word read gives full result, bit 8 data
// - byte mode low read gives eight LSBs
// - high read: MSBs, channel tag, zero bit
// - bus driven only while select and read low
// - result on bus before busy falls
// - word write loads whole control word
// - mask register takes one write, any mode
// - write data taken at write strobe release
// - reset selects normal power mode
// - normal mode stays powered always; a write to it as an auto-mode conversion ends keeps PW_OFF/PW_STBY
// - auto shutdown after each conversion
// - auto standby after each conversion
// - full shutdown on write until selects change
module aphi_parallel_port
   import aphi_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // host strobes, asynchronous pins
   input wire logic conversion_start_n_in,
   input wire logic conversion_clock_in,
   input wire logic chip_select_n_in,
   input wire logic read_n_in,
   input wire logic write_n_in,
   input wire logic word_mode_in,
   // data lines; line 8 is shared_bit8_line
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe_out,
   // converter core
   input wire logic [DATA_W-1:0] conv_code_in,
   input wire logic [CHAN_W-1:0] conv_channel_in,
   output logic busy_out,
   output logic sampler_track_out,
   // power and configuration
   output logic [1:0] power_mode_out,
   output logic standby_out,
   output logic powered_down_out,
   output logic [DATA_W-1:0] control_word_out,
   output logic [MASK_W-1:0] channel_mask_out,
   // result stream
   output aphi_result_t stream_data_out,
   output logic stream_valid_out,
   input wire logic stream_ready_in
);
   function automatic logic [DATA_W-1:0] read_format(input aphi_result_t r,
                                                     input logic word,
                                                     input logic hi);
      if (word)
      begin
         read_format = r.code;
      end
      else if (hi)
      begin
         read_format = {UPPER_PAD, TAG_ZERO, r.chan, r.code[DATA_W-1:BYTE_W]};
      end
      else
      begin
         read_format = {UPPER_PAD, r.code[BYTE_W-1:0]};
      end
   endfunction

   // pin synchronisers
   aphi_pins_t pin_raw, pin_s1_reg, pin_s2_reg, pin_s3_reg;
   aphi_pins_t pin_reg, pin_prev_reg, pin_next;
   logic [DATA_W-1:0] data_s1_reg, data_s2_reg, data_s3_reg;
   logic [DATA_W-1:0] data_hold_reg, data_hold_next;

   // state
   aphi_conv_t conv_reg, conv_next;
   aphi_pwr_t pwr_reg, pwr_next;
   logic [3:0] fall_cnt_reg, fall_cnt_next, rise_cnt_reg, rise_cnt_next;
   logic busy_reg, busy_next, track_reg, track_next;
   logic [DATA_W-1:0] ctrl_reg, ctrl_next;
   logic [BYTE_W-1:0] low_byte_reg, low_byte_next;
   logic [MASK_W-1:0] mask_reg, mask_next;
   logic mask_arm_reg, mask_arm_next;
   aphi_result_t result_reg, result_next, pending_reg, pending_next;
   logic [DATA_W-1:0] data_out_reg, data_out_next, data_oe_reg, data_oe_next;
   aphi_result_t stream_data_reg, stream_data_next;
   logic stream_valid_reg, stream_valid_next;

   // decoded events
   wire logic start_fall, start_rise, clk_fall, clk_rise;
   wire logic read_act, write_act, write_done, word_mode, wr_is_hi;
   wire logic mask_write, ctrl_write, low_write, completing, finish;
   wire logic [DATA_W-1:0] new_ctrl;
   wire logic [1:0] new_pm, pm;
   wire aphi_result_t conv_word, shown_word, fifo_out_data;
   wire logic fifo_in_ready, fifo_out_valid, fifo_out_ready;

   assign pin_raw = {conversion_start_n_in, conversion_clock_in, chip_select_n_in,
                     read_n_in, write_n_in, word_mode_in, data_in[SHARED_BIT]};
   // a bit moves only once stages two and three agree
   assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
   assign data_hold_next = (write_act && data_s2_reg == data_s3_reg) ? data_s3_reg
                                                                     : data_hold_reg;

   assign start_fall = pin_prev_reg.start_n & ~pin_reg.start_n;
   assign start_rise = ~pin_prev_reg.start_n & pin_reg.start_n;
   assign clk_fall = pin_prev_reg.conv_clk & ~pin_reg.conv_clk;
   assign clk_rise = ~pin_prev_reg.conv_clk & pin_reg.conv_clk;
   assign word_mode = pin_reg.word_mode;
   assign read_act = ~pin_reg.cs_n & ~pin_reg.rd_n;
   assign write_act = ~pin_reg.cs_n & ~pin_reg.wr_n;
   assign write_done = ~pin_prev_reg.cs_n & ~pin_prev_reg.wr_n & ~write_act;

   // write steering; high-byte upper nibble is dropped, host keeps it zero
   assign wr_is_hi = ~word_mode & data_hold_reg[SHARED_BIT];
   assign mask_write = write_done & mask_arm_reg;
   assign ctrl_write = write_done & ~mask_arm_reg & (word_mode | wr_is_hi);
   assign low_write = write_done & ~mask_arm_reg & ~word_mode & ~wr_is_hi;
   assign new_ctrl = word_mode ? data_hold_reg
                               : {data_hold_reg[3:0], low_byte_reg};
   assign new_pm = {new_ctrl[PM_HI_BIT], new_ctrl[PM_LO_BIT]};
   assign pm = {ctrl_reg[PM_HI_BIT], ctrl_reg[PM_LO_BIT]};

   // conversion end and the word shown on the bus
   assign completing = (conv_reg == CV_CONV) & clk_fall &
                       (fall_cnt_reg == CONV_FALL_EDGES - CNT_ONE);
   assign finish = (conv_reg == CV_LOAD) & fifo_in_ready;
   assign conv_word = {conv_channel_in, conv_code_in};
   // new result reaches the bus at least one cycle ahead of busy falling, more while the result FIFO is full
   assign shown_word = completing ? conv_word :
                       (conv_reg == CV_LOAD) ? pending_reg : result_reg;
   assign data_out_next = read_format(shown_word, word_mode, pin_reg.upper_half);
   assign data_oe_next = read_act ? (word_mode ? OE_WORD : OE_BYTE) : OE_NONE;
   assign pending_next = completing ? conv_word : pending_reg;
   assign result_next = finish ? pending_reg : result_reg;

   assign ctrl_next = ctrl_write ? new_ctrl : ctrl_reg;
   assign low_byte_next = low_write ? data_hold_reg[BYTE_W-1:0] : low_byte_reg;
   assign mask_next = mask_write ? data_hold_reg[MASK_W-1:0] : mask_reg;
   assign mask_arm_next = ctrl_write ? new_ctrl[MASK_ARM_BIT] :
                          mask_write ? 1'b0 : mask_arm_reg;

   // output stage keeps the stream port straight from flops
   assign fifo_out_ready = ~stream_valid_reg | stream_ready_in;
   assign stream_valid_next = fifo_out_valid | (stream_valid_reg & ~stream_ready_in);
   assign stream_data_next = (fifo_out_valid & fifo_out_ready) ? fifo_out_data
                                                               : stream_data_reg;

   always_comb
   begin
      conv_next = conv_reg;
      pwr_next = pwr_reg;
      fall_cnt_next = fall_cnt_reg;
      rise_cnt_next = rise_cnt_reg;
      busy_next = busy_reg;
      track_next = track_reg;
      unique case (conv_reg)
         CV_IDLE:
         begin
            if (start_fall && pm != PM_FULL_OFF)
            begin
               conv_next = CV_CONV;
               busy_next = 1'b1;
               track_next = 1'b0;
               fall_cnt_next = CNT_ZERO;
               rise_cnt_next = CNT_ZERO;
            end
            else if (start_rise && pm != PM_FULL_OFF)
            begin
               track_next = 1'b1;
               pwr_next = PW_ON;
            end
         end
         CV_CONV:
         begin
            if (start_rise)
            begin
               conv_next = CV_IDLE;
               busy_next = 1'b0;
               track_next = 1'b1;
            end
            else
            begin
               if (clk_fall)
               begin
                  fall_cnt_next = fall_cnt_reg + CNT_ONE;
               end
               if (clk_rise)
               begin
                  rise_cnt_next = rise_cnt_reg + CNT_ONE;
                  if (rise_cnt_reg == TRACK_RISE_EDGES - CNT_ONE)
                  begin
                     track_next = 1'b1;
                  end
               end
               if (completing)
               begin
                  conv_next = CV_LOAD;
               end
            end
         end
         CV_LOAD:
         begin
            // a full result FIFO holds busy high until room appears
            if (finish)
            begin
               conv_next = CV_IDLE;
               busy_next = 1'b0;
               if (pm == PM_AUTO_OFF)
               begin
                  pwr_next = PW_OFF;
                  track_next = 1'b0;
               end
               else if (pm == PM_AUTO_STBY)
               begin
                  pwr_next = PW_STBY;
                  track_next = 1'b0;
               end
            end
         end
      endcase
      // normal mode never leaves PW_ON on its own
      if (ctrl_write && new_pm == PM_FULL_OFF)
      begin
         pwr_next = PW_OFF;
         track_next = 1'b0;
      end
      else if (ctrl_write && pwr_reg != PW_ON && (pm == PM_FULL_OFF || new_pm == PM_NORMAL))
      begin
         pwr_next = PW_ON;
         track_next = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      data_s3_reg <= data_s2_reg;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         pin_reg <= PINS_IDLE;
         pin_prev_reg <= PINS_IDLE;
         data_hold_reg <= DATA_RESET;
         conv_reg <= CV_IDLE;
         pwr_reg <= PW_ON;
         fall_cnt_reg <= CNT_ZERO;
         rise_cnt_reg <= CNT_ZERO;
         busy_reg <= 1'b0;
         track_reg <= 1'b0;
         ctrl_reg <= CTRL_RESET;
         low_byte_reg <= MASK_RESET;
         mask_reg <= MASK_RESET;
         mask_arm_reg <= 1'b0;
         result_reg <= RESULT_RESET;
         pending_reg <= RESULT_RESET;
         data_out_reg <= DATA_RESET;
         data_oe_reg <= OE_NONE;
         stream_data_reg <= RESULT_RESET;
         stream_valid_reg <= 1'b0;
      end
      else
      begin
         pin_reg <= pin_next;
         pin_prev_reg <= pin_reg;
         data_hold_reg <= data_hold_next;
         conv_reg <= conv_next;
         pwr_reg <= pwr_next;
         fall_cnt_reg <= fall_cnt_next;
         rise_cnt_reg <= rise_cnt_next;
         busy_reg <= busy_next;
         track_reg <= track_next;
         ctrl_reg <= ctrl_next;
         low_byte_reg <= low_byte_next;
         mask_reg <= mask_next;
         mask_arm_reg <= mask_arm_next;
         result_reg <= result_next;
         pending_reg <= pending_next;
         data_out_reg <= data_out_next;
         data_oe_reg <= data_oe_next;
         stream_data_reg <= stream_data_next;
         stream_valid_reg <= stream_valid_next;
      end
   end

   aphi_result_fifo #(
      .WIDTH(RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) result_fifo (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .in_valid_in(conv_reg == CV_LOAD),
      .in_ready_out(fifo_in_ready),
      .in_data_in(pending_reg),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );

   assign data_out = data_out_reg;
   assign data_oe_out = data_oe_reg;
   assign busy_out = busy_reg;
   assign sampler_track_out = track_reg;
   assign power_mode_out = pm;
   assign standby_out = (pwr_reg == PW_STBY);
   assign powered_down_out = (pwr_reg == PW_OFF);
   assign control_word_out = ctrl_reg;
   assign channel_mask_out = mask_reg;
   assign stream_data_out = stream_data_reg;
   assign stream_valid_out = stream_valid_reg;
endmodule
`default_nettype wire

/* rtl/aphi_pkg.sv */
// shared constants and types for the converter parallel host port
// assumes a single 250 MHz clock and asynchronous host pins
package aphi_pkg;
   localparam int DATA_W = 12;
   localparam int BYTE_W = 8;
   localparam int CHAN_W = 3;
   localparam int MASK_W = 8;
   localparam int FIFO_DEPTH = 16;
   // data line that doubles as upper_half_select in byte mode
   localparam int SHARED_BIT = 8;
   // control word fields (power selects and mask-load arm)
   localparam int PM_LO_BIT = 4;
   localparam int PM_HI_BIT = 5;
   localparam int MASK_ARM_BIT = 3;
   localparam logic [DATA_W-1:0] CTRL_RESET = 12'h000;
   localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
   localparam logic [3:0] UPPER_PAD = 4'h0;
   localparam logic TAG_ZERO = 1'b0;
   localparam logic [DATA_W-1:0] OE_WORD = 12'hfff;
   localparam logic [DATA_W-1:0] OE_BYTE = 12'h0ff;
   localparam logic [DATA_W-1:0] OE_NONE = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
   // conversion clock edge counts
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CONV_FALL_EDGES = 4'he;
   localparam logic [3:0] TRACK_RISE_EDGES = 4'hd;
   // power selects {power_sel_hi, power_sel_lo}
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_AUTO_OFF = 2'h1;
   localparam logic [1:0] PM_AUTO_STBY = 2'h2;
   localparam logic [1:0] PM_FULL_OFF = 2'h3;

   typedef struct packed {
      logic start_n;
      logic conv_clk;
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic word_mode;
      logic upper_half;
   } aphi_pins_t;

   localparam aphi_pins_t PINS_IDLE = '{start_n: 1'b1, conv_clk: 1'b0, cs_n: 1'b1,
      rd_n: 1'b1, wr_n: 1'b1, word_mode: 1'b1, upper_half: 1'b0};

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [DATA_W-1:0] code;
   } aphi_result_t;

   localparam int RESULT_W = $bits(aphi_result_t);
   localparam aphi_result_t RESULT_RESET = '{chan: 3'h0, code: 12'h000};

   typedef enum logic [2:0] {
      CV_IDLE = 3'b001,
      CV_CONV = 3'b010,
      CV_LOAD = 3'b100
   } aphi_conv_t;

   typedef enum logic [2:0] {
      PW_ON = 3'b001,
      PW_STBY = 3'b010,
      PW_OFF = 3'b100
   } aphi_pwr_t;
endpackage

/* rtl/aphi_result_fifo.sv */
// result FIFO with valid/ready on both sides
// assumes DEPTH is a power of two; one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module aphi_result_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg, rd_ptr_reg;
   wire logic full, empty, push, pop;

   // extra pointer bit tells full from empty without a counter
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign push = in_valid_in & ~full;
   assign pop = out_ready_in & ~empty;
   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      end
   end
endmodule
`default_nettype wire
